// File: tsc_pkg.sv
// Package with shared constants and types for the touch sensor serial link
package tsc_pkg;
  // ==========================================================
  // Bus addressing
  localparam logic [6:0] ADDR_VARIANT_A = 7'h28;
  localparam logic [6:0] ADDR_VARIANT_B = 7'h29;
  localparam int         BYTE_BITS      = 8;
  localparam logic [3:0] BIT_CNT_RST    = 4'h0;
  localparam logic [7:0] PTR_RST        = 8'h00;
  localparam logic [7:0] BYTE_RST       = 8'h00;
  localparam logic [2:0] SYNC_RST       = 3'h7;
  // ==========================================================
  // Timing
  localparam int CLK_MHZ         = 125;
  localparam int TIMEOUT_MS      = 30;
  localparam int IDLE_US         = 200;
  localparam int TIMEOUT_CYC     = TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int IDLE_CYC        = IDLE_US * CLK_MHZ;
  localparam int SCL_MIN_KHZ     = 10;
  localparam int SCL_MAX_KHZ     = 400;
  // Quarter of a bit time, rounded up so the link never runs above its top rate
  localparam int HOST_HALF_CYC   = (CLK_MHZ * 1000 + SCL_MAX_KHZ * 4 - 1) / (SCL_MAX_KHZ * 4);
  localparam logic [23:0] CNT_RST = 24'h000000;
  // ==========================================================
  // Buffering
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_WIDTH = 9;
  // ==========================================================
  // Host commands
  typedef enum logic [1:0] {
    TSC_CMD_WRITE,
    TSC_CMD_READ,
    TSC_CMD_SET_PTR,
    TSC_CMD_READ_CUR
  } tsc_cmd_t;
endpackage

// File: tsc_if.sv
// Two-wire serial link between host and touch sensor client
`timescale 1ns/1ns
interface tsc_if;
  logic scl_o;   // Host clock drive low
  logic scl_oe;  // Host clock enable
  logic sda_h_o; // Host data value
  logic sda_h_oe; // Host data enable
  logic sda_d_o; // Device data value
  logic sda_d_oe; // Device data enable
  logic scl;     // Resolved clock level
  logic sda;     // Resolved data level
  assign scl = scl_oe ? scl_o : 1'b1;
  assign sda = (sda_h_oe & ~sda_h_o) | (sda_d_oe & ~sda_d_o) ? 1'b0 : 1'b1;
  modport host (output scl_o, scl_oe, sda_h_o, sda_h_oe, input scl, sda);
  modport device (output sda_d_o, sda_d_oe, input scl, sda);
endinterface

// File: tsc_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ns
module tsc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys, // System clock
  input  wire logic             nrst,    // Async reset, active low
  input  wire logic [WIDTH-1:0] in_data, // Write data
  input  wire logic             in_valid, // Write request
  output logic                  in_ready, // Not full
  output logic      [WIDTH-1:0] out_data, // Head word
  output logic                  out_valid, // Not empty
  input  wire logic             out_ready  // Drain
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0]      wp_ff, rp_ff, nxt_wp, nxt_rp;
  logic             push, pop;
  assign in_ready  = (wp_ff - rp_ff) != (AW+1)'(DEPTH);
  assign out_valid = wp_ff != rp_ff;
  assign out_data  = mem_ff[rp_ff[AW-1:0]];
  assign push = in_valid & in_ready;
  assign pop  = out_valid & out_ready;
  always_comb begin
    nxt_wp = wp_ff + (AW+1)'(push);
    nxt_rp = rp_ff + (AW+1)'(pop);
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wp_ff <= '0;
      rp_ff <= '0;
    end else begin
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_ff[wp_ff[AW-1:0]] <= in_data;
    end
  end
endmodule

// File: tsc_client.sv
// Device end: serial client of the touch sensor
// How it works
// (RULE_01) Bytes are eight bits, MSB first
// (RULE_02) Client acknowledges every received byte
// (RULE_03) Host acks read bytes except last
// (RULE_04) Stop resets client logic
// (RULE_05) Clock low 30ms aborts when enabled
// (RULE_06) Timeout disabled until enable bit set
// (RULE_07) Both lines high 200us resets state
// (RULE_08) Clock between 10kHz and 400kHz
// (RULE_09) Plain byte counting, no count byte
// (RULE_10) Write: address, index, data, stop
// (RULE_11) Read: index, restart, read one byte
// (RULE_12) Index-only write loads pointer only
// (RULE_13) Indexless read uses pointer, leaves it
// (RULE_14) Deep sleep may break pointer-only forms
// (RULE_15) Block read increments pointer, wraps
// (RULE_16) Block write stores then increments pointer
// (RULE_17) Status poll or touch interrupt offered
// (RULE_18) Never stretch clock, tolerate stretching
// (RULE_19) First byte: address then direction bit
// (RULE_20) Answer only to selected variant address
// (RULE_21) Start is data falling, clock high
// (RULE_22) Unmatched address: stay released, passive
`timescale 1ns/1ns
module tsc_client #(
  parameter int TIMEOUT_CYC = tsc_pkg::TIMEOUT_CYC,
  parameter int IDLE_CYC    = tsc_pkg::IDLE_CYC
) (
  input  wire logic       clk_sys,      // System clock
  input  wire logic       nrst,         // Async reset, active low
  tsc_if.device           bus,          // Serial link
  input  wire logic       addr_sel,     // Variant address select
  input  wire logic       timeout_en,   // Timeout/idle enable
  output logic [7:0]      reg_addr,     // Register index of access
  output logic [7:0]      reg_wdata,    // Write data
  output logic            reg_wr,       // Write pulse
  output logic            reg_rd,       // Read request pulse
  input  wire logic [7:0] reg_rdata,    // Read data
  output logic [7:0]      pointer,      // Current register pointer
  output logic            busy          // Transaction running: address byte or addressed transfer
);
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK, ST_RX, ST_TX, ST_TXACK, ST_IGN} tsc_st_t;
  // ==========================================================
  // Synchronisers and edge detection
  logic [2:0] scl_sy_ff, sda_sy_ff, nxt_scl_sy, nxt_sda_sy;
  logic       scl_rise, scl_fall, start_c, stop_c, scl_l, sda_l;
  always_comb begin
    nxt_scl_sy = {scl_sy_ff[1:0], bus.scl};
    nxt_sda_sy = {sda_sy_ff[1:0], bus.sda};
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      scl_sy_ff <= tsc_pkg::SYNC_RST;
      sda_sy_ff <= tsc_pkg::SYNC_RST;
    end else begin
      scl_sy_ff <= nxt_scl_sy;
      sda_sy_ff <= nxt_sda_sy;
    end
  end
  assign scl_l    = scl_sy_ff[1];
  assign sda_l    = sda_sy_ff[1];
  assign scl_rise = scl_sy_ff[1] & ~scl_sy_ff[2];
  assign scl_fall = ~scl_sy_ff[1] & scl_sy_ff[2];
  assign start_c  = scl_l & scl_sy_ff[2] & ~sda_sy_ff[1] & sda_sy_ff[2]; // see RULE_21
  assign stop_c   = scl_l & scl_sy_ff[2] & sda_sy_ff[1] & ~sda_sy_ff[2];  // see RULE_04
  // ==========================================================
  // Protocol engine
  tsc_st_t    st_ff, nxt_st;
  logic [3:0] bit_ff, nxt_bit;
  logic [7:0] sh_ff, nxt_sh, ptr_ff, nxt_ptr, wd_ff, nxt_wd, ra_ff, nxt_ra;
  logic       rw_ff, nxt_rw, first_ff, nxt_first, drv_ff, nxt_drv;
  logic       wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic [23:0] cnt_ff, nxt_cnt;
  logic       abort;
  logic [6:0] my_addr;
  assign my_addr = addr_sel ? tsc_pkg::ADDR_VARIANT_B : tsc_pkg::ADDR_VARIANT_A; // see RULE_20
  // Timeout counts clock low, idle counts both high; both run only while timeout_en is high
  always_comb begin
    nxt_cnt = tsc_pkg::CNT_RST;
    abort   = 1'b0;
    if (timeout_en && st_ff != ST_IDLE && (!scl_l || sda_l) && !scl_rise && !scl_fall) begin
      nxt_cnt = cnt_ff + 24'h000001;
      if (!scl_l && cnt_ff >= 24'(TIMEOUT_CYC - 1)) begin
        abort = 1'b1; // see RULE_05 see RULE_06
      end
      if (scl_l && cnt_ff >= 24'(IDLE_CYC)) begin
        abort = 1'b1; // see RULE_07
      end
    end
  end
  always_comb begin
    nxt_st = st_ff;
    nxt_bit = bit_ff;
    nxt_sh = sh_ff;
    nxt_ptr = ptr_ff;
    nxt_wd = wd_ff;
    nxt_ra = ra_ff;
    nxt_rw = rw_ff;
    nxt_first = first_ff;
    nxt_drv = drv_ff;
    nxt_wr = 1'b0;
    nxt_rd = 1'b0;
    if (start_c) begin
      nxt_st = ST_ADDR;
      nxt_bit = tsc_pkg::BIT_CNT_RST;
      nxt_drv = 1'b0;
    end else if (stop_c || abort) begin
      nxt_st = ST_IDLE; // see RULE_04
      nxt_drv = 1'b0;
    end else begin
      unique case (st_ff)
        ST_IDLE, ST_IGN: begin
          nxt_drv = 1'b0; // see RULE_22
        end
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            nxt_sh = {sh_ff[6:0], sda_l}; // see RULE_01
            nxt_bit = bit_ff + 4'h1;
          end
          if (scl_fall && bit_ff == 4'(tsc_pkg::BYTE_BITS)) begin
            nxt_bit = tsc_pkg::BIT_CNT_RST;
            if (st_ff == ST_ADDR) begin
              if (sh_ff[7:1] == my_addr) begin // see RULE_19
                nxt_rw = sh_ff[0];
                nxt_first = 1'b1;
                nxt_drv = 1'b1; // see RULE_02
                nxt_st = ST_ACK;
                if (sh_ff[0]) begin
                  nxt_ra = ptr_ff; // see RULE_13
                  nxt_rd = 1'b1;
                end
              end else begin
                nxt_st = ST_IGN; // see RULE_22
              end
            end else begin
              nxt_drv = 1'b1; // see RULE_02
              nxt_st = ST_ACK;
              if (first_ff) begin
                nxt_ptr = sh_ff; // see RULE_12 see RULE_14
                nxt_first = 1'b0;
              end else begin
                nxt_wd = sh_ff; // see RULE_10 see RULE_16
                nxt_ra = ptr_ff;
                nxt_wr = 1'b1;
                nxt_ptr = ptr_ff + 8'h01;
              end
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (rw_ff) begin
              nxt_st = ST_TX;
              nxt_sh = reg_rdata; // see RULE_11
              nxt_drv = ~reg_rdata[7];
              nxt_bit = 4'h1;
            end else begin
              nxt_st = ST_RX;
              nxt_drv = 1'b0;
              nxt_bit = tsc_pkg::BIT_CNT_RST;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_ff == 4'(tsc_pkg::BYTE_BITS)) begin
              nxt_drv = 1'b0;
              nxt_st = ST_TXACK;
            end else begin
              nxt_drv = ~sh_ff[7 - bit_ff[2:0]]; // see RULE_01
              nxt_bit = bit_ff + 4'h1;
            end
          end
        end
        ST_TXACK: begin
          // Pointer steps only on the host's ack, so a lone indexless read leaves it
          if (scl_rise) begin
            nxt_st = ST_IGN;
            if (~sda_l) begin
              nxt_ptr = ptr_ff + 8'h01; // see RULE_15 see RULE_13
              nxt_ra  = ptr_ff + 8'h01; // see RULE_03 see RULE_09
              nxt_rd  = 1'b1;
              nxt_st  = ST_ACK;
            end
          end
        end
        default: nxt_st = ST_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_ff <= ST_IDLE;
      bit_ff <= tsc_pkg::BIT_CNT_RST;
      sh_ff <= tsc_pkg::BYTE_RST;
      ptr_ff <= tsc_pkg::PTR_RST;
      wd_ff <= tsc_pkg::BYTE_RST;
      ra_ff <= tsc_pkg::BYTE_RST;
      rw_ff <= 1'b0;
      first_ff <= 1'b0;
      drv_ff <= 1'b0;
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      cnt_ff <= tsc_pkg::CNT_RST;
    end else begin
      st_ff <= nxt_st;
      bit_ff <= nxt_bit;
      sh_ff <= nxt_sh;
      ptr_ff <= nxt_ptr;
      wd_ff <= nxt_wd;
      ra_ff <= nxt_ra;
      rw_ff <= nxt_rw;
      first_ff <= nxt_first;
      drv_ff <= nxt_drv;
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end
  // Data is only ever pulled low; the clock line is never driven
  assign bus.sda_d_o  = 1'b0; // see RULE_18
  assign bus.sda_d_oe = drv_ff;
  assign reg_addr  = ra_ff;
  assign reg_wdata = wd_ff;
  assign reg_wr    = wr_ff;
  assign reg_rd    = rd_ff; // see RULE_17
  assign pointer   = ptr_ff;
  assign busy      = st_ff != ST_IDLE && st_ff != ST_IGN;
endmodule

// File: tsc_host.sv
// Host end: master that runs register transactions over the link
`timescale 1ns/1ns
module tsc_host (
  input  wire logic       clk_sys,    // System clock
  input  wire logic       nrst,       // Async reset, active low
  tsc_if.host             bus,        // Serial link
  input  wire logic [6:0] dev_addr,   // Target address
  input  wire logic       cmd_valid,  // Command request
  output logic            cmd_ready,  // Idle and accepts
  input  wire tsc_pkg::tsc_cmd_t cmd, // Command kind
  input  wire logic [7:0] cmd_index,  // Register index
  input  wire logic [3:0] cmd_len,    // Byte count minus one
  input  wire logic [7:0] wr_data,    // Write stream data
  input  wire logic       wr_valid,   // Write stream valid
  output logic            wr_ready,   // Write stream ready
  output logic [7:0]      rd_data,    // Read stream data
  output logic            rd_valid,   // Read stream valid
  input  wire logic       rd_ready,   // Read stream ready
  output logic            nack_err    // Pulse: device did not ack
);
  typedef enum logic [2:0] {H_IDLE, H_START, H_BYTE, H_ACK, H_STOP, H_WAIT} tsc_hst_t;
  // ==========================================================
  // Read FIFO: host stalls on a full FIFO before next read byte
  logic [8:0] fi_d, fo_d;
  logic       fi_v, fi_r;
  tsc_fifo #(.WIDTH(tsc_pkg::FIFO_WIDTH), .DEPTH(tsc_pkg::FIFO_DEPTH)) u_tsc_fifo (
    .clk_sys(clk_sys), .nrst(nrst), .in_data(fi_d), .in_valid(fi_v), .in_ready(fi_r),
    .out_data(fo_d), .out_valid(rd_valid), .out_ready(rd_ready));
  assign rd_data = fo_d[7:0];
  // ==========================================================
  // Clock divider and sequencer; this end makes the link clock
  tsc_hst_t   st_ff, nxt_st;
  logic [7:0] div_ff, nxt_div, sh_ff, nxt_sh;
  logic [3:0] bit_ff, nxt_bit, left_ff, nxt_left;
  logic [1:0] ph_ff, nxt_ph, seg_ff, nxt_seg;
  logic       scl_lo_ff, nxt_scl_lo, sda_lo_ff, nxt_sda_lo, rx_ff, nxt_rx;
  logic       err_ff, nxt_err, push_ff, nxt_push;
  logic [2:0] sy_ff, nxt_sy;
  tsc_pkg::tsc_cmd_t cmd_ff, nxt_cmd;
  logic [7:0] idx_ff, nxt_idx;
  logic       tick, sda_s, wr_slot, wr_hold;
  always_comb nxt_sy = {sy_ff[1:0], bus.sda};
  assign sda_s = sy_ff[1];
  assign tick  = div_ff == 8'(tsc_pkg::HOST_HALF_CYC - 1); // see RULE_08
  assign cmd_ready = st_ff == H_IDLE;
  assign wr_slot   = seg_ff == 2'h2 && bit_ff == 4'h0 && ph_ff == 2'h0;
  // The clock is stretched low before a write byte until the stream offers one
  assign wr_hold   = wr_slot && !wr_valid;
  assign wr_ready  = st_ff == H_BYTE && tick && wr_slot && wr_valid;
  always_comb begin
    nxt_st = st_ff; nxt_div = tick ? 8'h00 : div_ff + 8'h01;
    nxt_sh = sh_ff; nxt_bit = bit_ff; nxt_left = left_ff; nxt_ph = ph_ff;
    nxt_seg = seg_ff; nxt_scl_lo = scl_lo_ff; nxt_sda_lo = sda_lo_ff;
    nxt_rx = rx_ff; nxt_err = 1'b0; nxt_push = 1'b0; nxt_cmd = cmd_ff; nxt_idx = idx_ff;
    unique case (st_ff)
      H_IDLE: begin
        nxt_scl_lo = 1'b0; nxt_sda_lo = 1'b0; nxt_div = 8'h00;
        if (cmd_valid) begin
          nxt_cmd = cmd; nxt_idx = cmd_index; nxt_left = cmd_len;
          nxt_rx = 1'b0; nxt_st = H_START; nxt_ph = 2'h0;
          nxt_seg = (cmd == tsc_pkg::TSC_CMD_READ_CUR) ? 2'h1 : 2'h0;
        end
      end
      H_START: if (tick) begin
        nxt_ph = ph_ff + 2'h1;
        unique case (ph_ff)
          2'h0: begin nxt_scl_lo = 1'b0; nxt_sda_lo = 1'b0; end
          2'h1: nxt_sda_lo = 1'b1; // start: data falls, clock high
          default: begin
            nxt_scl_lo = 1'b1; nxt_st = H_BYTE; nxt_bit = 4'h0; nxt_ph = 2'h0;
            nxt_rx = 1'b0;
            if (seg_ff == 2'h1) begin
              nxt_sh = {dev_addr, 1'b1};
            end else begin
              nxt_sh = {dev_addr, 1'b0};
            end
          end
        endcase
      end
      H_BYTE: if (tick && !wr_hold) begin
        // Data phase: 0 set data, 1 clock high, 2 sample, 3 clock low
        nxt_ph = ph_ff + 2'h1;
        unique case (ph_ff)
          2'h0: begin
            if (seg_ff == 2'h2 && bit_ff == 4'h0 && !rx_ff) nxt_sh = wr_data;
            nxt_sda_lo = rx_ff ? 1'b0 :
                         (seg_ff == 2'h2 && bit_ff == 4'h0) ? ~wr_data[7] : ~sh_ff[7];
          end
          2'h1: nxt_scl_lo = 1'b0;
          2'h2: if (rx_ff) nxt_sh = {sh_ff[6:0], sda_s};
          default: begin
            nxt_scl_lo = 1'b1;
            if (!rx_ff) nxt_sh = {sh_ff[6:0], 1'b0};
            nxt_bit = bit_ff + 4'h1;
            if (bit_ff == 4'h7) nxt_st = H_ACK;
          end
        endcase
      end
      H_ACK: if (tick) begin
        nxt_ph = ph_ff + 2'h1;
        unique case (ph_ff)
          2'h0: nxt_sda_lo = rx_ff && left_ff != 4'h0; // Ack all but final read byte, see RULE_03
          2'h1: nxt_scl_lo = 1'b0;
          2'h2: begin
            if (!rx_ff && sda_s) nxt_err = 1'b1;
            if (rx_ff) nxt_push = 1'b1;
          end
          default: begin
            nxt_scl_lo = 1'b1; nxt_bit = 4'h0; nxt_st = H_BYTE;
            if (err_ff) begin
              nxt_st = H_STOP;
            end else if (rx_ff) begin
              nxt_left = left_ff - 4'h1;
              if (left_ff == 4'h0) nxt_st = H_STOP;
              else if (!fi_r) nxt_st = H_WAIT;
            end else if (seg_ff == 2'h0) begin
              nxt_sh = idx_ff; nxt_seg = 2'h3;
            end else if (seg_ff == 2'h3) begin
              if (cmd_ff == tsc_pkg::TSC_CMD_SET_PTR) nxt_st = H_STOP;
              else if (cmd_ff == tsc_pkg::TSC_CMD_WRITE) nxt_seg = 2'h2;
              else begin nxt_seg = 2'h1; nxt_st = H_START; nxt_ph = 2'h0; end
            end else if (seg_ff == 2'h1) begin
              nxt_rx = 1'b1;
            end else begin
              nxt_left = left_ff - 4'h1;
              if (left_ff == 4'h0) nxt_st = H_STOP;
            end
          end
        endcase
      end
      H_WAIT: begin
        nxt_div = 8'h00;
        if (fi_r) nxt_st = H_BYTE;
      end
      H_STOP: if (tick) begin
        nxt_ph = ph_ff + 2'h1;
        unique case (ph_ff)
          2'h0: nxt_sda_lo = 1'b1;
          2'h1: nxt_scl_lo = 1'b0;
          2'h2: nxt_sda_lo = 1'b0; // stop: data rises, clock high
          default: nxt_st = H_IDLE;
        endcase
      end
      default: nxt_st = H_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_ff <= H_IDLE; div_ff <= 8'h00; sh_ff <= tsc_pkg::BYTE_RST;
      bit_ff <= tsc_pkg::BIT_CNT_RST; left_ff <= 4'h0; ph_ff <= 2'h0; seg_ff <= 2'h0;
      scl_lo_ff <= 1'b0; sda_lo_ff <= 1'b0; rx_ff <= 1'b0; err_ff <= 1'b0;
      push_ff <= 1'b0; sy_ff <= tsc_pkg::SYNC_RST;
      cmd_ff <= tsc_pkg::TSC_CMD_WRITE; idx_ff <= tsc_pkg::BYTE_RST;
    end else begin
      st_ff <= nxt_st; div_ff <= nxt_div; sh_ff <= nxt_sh; bit_ff <= nxt_bit;
      left_ff <= nxt_left; ph_ff <= nxt_ph; seg_ff <= nxt_seg; scl_lo_ff <= nxt_scl_lo;
      sda_lo_ff <= nxt_sda_lo; rx_ff <= nxt_rx; push_ff <= nxt_push; sy_ff <= nxt_sy;
      cmd_ff <= nxt_cmd; idx_ff <= nxt_idx;
      err_ff <= (st_ff == H_IDLE) ? 1'b0 : (err_ff | nxt_err);
    end
  end
  assign fi_d = {1'b0, sh_ff};
  assign fi_v = push_ff;
  assign bus.scl_o    = 1'b0;
  assign bus.scl_oe   = scl_lo_ff;
  assign bus.sda_h_o  = 1'b0;
  assign bus.sda_h_oe = sda_lo_ff;
  assign nack_err     = nxt_err;
endmodule

// File: tsc_chk_properties.sv
// Checker of the two-wire link between the host and the touch sensor client
`timescale 1ns/1ns
module tsc_chk #(
  parameter logic [6:0] DEV_ADDR = 7'h28
) (
  input wire logic clk_sys,  // System clock
  input wire logic nrst,     // Async reset, active low
  input wire logic scl,      // Resolved clock level
  input wire logic sda,      // Resolved data level
  input wire logic sda_d_o,  // Device data value
  input wire logic sda_d_oe  // Device data enable
);
  // ==========================================================
  // Frame tracker: bit slot 0..8 and saturating byte count since start
  logic       scl_ff, sda_ff, hit_ff, rd_ff, nxt_hit, nxt_rd, stop, ack_slot;
  logic [3:0] bit_ff, byte_ff, nxt_bit, nxt_byte;
  logic [7:0] sh_ff, nxt_sh;
  always_comb begin
    stop     = scl & scl_ff & ~sda_ff & sda;
    ack_slot = scl & ~scl_ff & (bit_ff == 4'h8);
    nxt_bit  = bit_ff;
    nxt_byte = byte_ff;
    nxt_sh   = sh_ff;
    nxt_hit  = hit_ff;
    nxt_rd   = rd_ff;
    if (stop | (scl & scl_ff & sda_ff & ~sda)) begin
      nxt_bit  = 4'h0;
      nxt_byte = 4'h0;
      nxt_hit  = 1'b0;
    end else if (scl & ~scl_ff) begin
      nxt_bit = ack_slot ? 4'h0 : bit_ff + 4'h1;
      if (!ack_slot) nxt_sh = {sh_ff[6:0], sda};
      if (ack_slot && byte_ff != 4'hf) nxt_byte = byte_ff + 4'h1;
      if (ack_slot && byte_ff == 4'h0) begin
        nxt_hit = (sh_ff[7:1] == DEV_ADDR);
        nxt_rd  = sh_ff[0];
      end
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      scl_ff  <= 1'b1;
      sda_ff  <= 1'b1;
      hit_ff  <= 1'b0;
      rd_ff   <= 1'b0;
      bit_ff  <= 4'h0;
      byte_ff <= 4'h0;
      sh_ff   <= 8'h00;
    end else begin
      scl_ff  <= scl;
      sda_ff  <= sda;
      hit_ff  <= nxt_hit;
      rd_ff   <= nxt_rd;
      bit_ff  <= nxt_bit;
      byte_ff <= nxt_byte;
      sh_ff   <= nxt_sh;
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  chk_addr_ack: assert property (ack_slot && byte_ff == 4'h0 && sh_ff[7:1] == DEV_ADDR |-> !sda)
    else $error("own address not acknowledged");
  chk_foreign_nack: assert property (ack_slot && byte_ff == 4'h0 && sh_ff[7:1] != DEV_ADDR |-> sda)
    else $error("foreign address acknowledged");
  chk_data_ack: assert property (ack_slot && byte_ff != 4'h0 && hit_ff && !rd_ff |-> !sda)
    else $error("written byte not acknowledged");
  chk_ack_release: assert property (ack_slot && byte_ff != 4'h0 && hit_ff && !rd_ff |-> ##[1:400] !sda_d_oe)
    else $error("acknowledge held past its slot");
  chk_idle_quiet: assert property (byte_ff != 4'h0 && !hit_ff |-> !sda_d_oe)
    else $error("client drives data while not addressed");
  chk_sda_hold: assert property (scl && scl_ff |-> $stable(sda_d_oe))
    else $error("client changed data while clock high");
  chk_stop_free: assert property (stop |-> (!sda_d_oe)[*8])
    else $error("client still drives after stop");
  chk_rd_release: assert property (ack_slot && byte_ff != 4'h0 && hit_ff && rd_ff |-> !(sda_d_oe && !sda_d_o))
    else $error("client blocks host acknowledge slot");
  cover property (ack_slot && hit_ff && rd_ff && byte_ff != 4'h0 && sda);
  cover property (ack_slot && byte_ff == 4'h0 && sh_ff[7:1] != DEV_ADDR);
  cover property (stop && hit_ff && !rd_ff);
endmodule

// File: tsc_tb.sv
// Self-checking bench: host and client joined over the link
`timescale 1ns/1ns
module tsc_tb;
  logic              clk_sys = 1'b0, nrst = 1'b0, timeout_en = 1'b0, stall = 1'b1;
  logic              cmd_valid = 1'b0, wr_valid = 1'b1, rd_ready = 1'b0;
  logic              cmd_ready, wr_ready, rd_valid, reg_wr, nack_err;
  logic [3:0]        cmd_len = 4'h0;
  logic [6:0]        dev_addr = 7'h28;
  logic [7:0]        cmd_index = 8'h00, wr_data = 8'h3c, rd_data, reg_addr, reg_wdata, pointer;
  logic [7:0]        ptr, regs [256], exp_mem [256];
  logic [15:0]       wq [$];
  logic [7:0]        rq [$];
  tsc_pkg::tsc_cmd_t cmd = tsc_pkg::TSC_CMD_WRITE;
  int                miscompares = 0, checks_done = 0, seed = 81048, cyc = 0, nacks = 0, n;
  always #4 clk_sys = ~clk_sys;
  tsc_if bus ();
  // Short timeout so a 3000-cycle stretch would abort if the enable were ignored
  tsc_client #(.TIMEOUT_CYC(2000), .IDLE_CYC(500)) u_tsc_client (.clk_sys(clk_sys),
    .nrst(nrst), .bus(bus), .addr_sel(1'b0), .timeout_en(timeout_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(), .reg_rdata(regs[reg_addr]),
    .pointer(pointer), .busy());
  tsc_host u_tsc_host (.clk_sys(clk_sys), .nrst(nrst), .bus(bus), .dev_addr(dev_addr),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .cmd_index(cmd_index),
    .cmd_len(cmd_len), .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready), .nack_err(nack_err));
  tsc_chk u_tsc_chk (.clk_sys(clk_sys), .nrst(nrst), .scl(bus.scl), .sda(bus.sda),
    .sda_d_o(bus.sda_d_o), .sda_d_oe(bus.sda_d_oe));
  // ==========================================================
  // Comparison and closing
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ==========================================================
  // Register file, write stream driver and result watcher
  always @(posedge clk_sys) begin
    if (reg_wr) regs[reg_addr] <= reg_wdata;
    rd_ready <= stall ? 1'b0 : 1'($random(seed));
    if (wr_ready || !wr_valid) wr_valid <= 1'($random(seed));
    if (wr_ready) begin
      wq.push_back({ptr, wr_data});
      exp_mem[ptr] = wr_data;
      ptr = ptr + 8'h01;
      wr_data <= 8'($random(seed));
    end
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (nack_err) nacks++;
    if (reg_wr) chk("reg write", {reg_addr, reg_wdata}, wq.size() ? wq.pop_front() : 'x);
    if (rd_valid && rd_ready) chk("read data", rd_data, rq.size() ? rq.pop_front() : 'x);
    if (cyc == 90000) begin
      miscompares++;
      close_out();
    end
  end
  // ==========================================================
  // Command driver: notes expected reads as it issues them
  task automatic run(input tsc_pkg::tsc_cmd_t c, input logic [7:0] idx, input logic [3:0] len);
    while (cmd_ready !== 1'b1) @(negedge clk_sys);
    @(posedge clk_sys);
    cmd <= c;
    cmd_index <= idx;
    cmd_len <= len;
    cmd_valid <= 1'b1;
    if (c != tsc_pkg::TSC_CMD_READ_CUR) ptr = idx;
    if (c == tsc_pkg::TSC_CMD_READ_CUR) rq.push_back(exp_mem[ptr]);
    for (int i = 0; i <= len && c == tsc_pkg::TSC_CMD_READ; i++) rq.push_back(exp_mem[8'(idx + i)]);
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    repeat (8) @(posedge clk_sys);
    while (cmd_ready !== 1'b1) @(negedge clk_sys);
    repeat (8) @(posedge clk_sys);
  endtask
  initial begin
    for (int i = 0; i < 256; i++) regs[i] = 8'(i * 7 + 3);
    for (int i = 0; i < 256; i++) exp_mem[i] = 8'(i * 7 + 3);
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    timeout_en <= 1'b1;
    stall <= 1'b0;
    run(tsc_pkg::TSC_CMD_WRITE, 8'hff, 4'h1);
    chk("pointer", pointer, 8'h01);
    run(tsc_pkg::TSC_CMD_SET_PTR, 8'hfa, 4'h0);
    chk("pointer", pointer, 8'hfa);
    run(tsc_pkg::TSC_CMD_READ_CUR, 8'h00, 4'h0);
    chk("pointer", pointer, 8'hfa);
    timeout_en <= 1'b0;
    stall <= 1'b1;
    fork
      run(tsc_pkg::TSC_CMD_READ, 8'hfa, 4'h9);
      begin
        // Release the stall only once the host has held the clock low well past the timeout
        n = 0;
        while (n < 3000) begin
          @(posedge clk_sys);
          n = bus.scl ? 0 : n + 1;
        end
        stall <= 1'b0;
      end
    join
    chk("pointer", pointer, 8'h03);
    dev_addr <= 7'h29;
    run(tsc_pkg::TSC_CMD_SET_PTR, 8'h10, 4'h0);
    chk("pointer", pointer, 8'h03);
    chk("nack count", 16'(nacks), 16'h0001);
    chk("pending", 16'(wq.size() + rq.size()), 16'h0000);
    close_out();
  end
endmodule
